// >>> design/rss_alu_pkg.sv
// Purpose: Shared constants and operation codes for the rotate/subtract/skip ALU
// Assumes: Decoder presents one operation per machine cycle
// Notes:   Flags follow the core's status layout
//
// Contract
// - Rotate-left-to-acc puts memory rotated left in acc; memory, flags kept.
// - Rotate-left-through-carry on memory: old carry into bit 0, bit 7 to carry.
// - Acc form of left-through-carry writes acc, carry from memory bit 7.
// - Rotate-right on memory: bit 0 into bit 7, no flag changes.
// - Rotate-right-to-acc puts memory rotated right in acc; memory, flags kept.
// - Rotate-right-through-carry on memory: old carry into bit 7, bit 0 to carry.
// - Acc form of right-through-carry writes acc, carry from memory bit 0.
// - Subtract-with-borrow: acc minus memory minus inverted carry into acc.
// - Memory form of subtract-with-borrow writes difference to memory.
// - Carry clears on negative result, sets on zero or positive.
// - Subtract-to-memory stores acc minus memory in memory, acc kept.
// - Immediate subtract takes the instruction constant from acc.
// - Decrement-skip writes memory minus one, skips on zero, no flags.
// - Acc form of decrement-skip writes acc, memory kept, skips on zero.
// - Increment-skip writes memory plus one, skips on zero wrap, no flags.
// - Acc form of increment-skip writes acc, memory kept, skips on zero.
// - Bit-nonzero skip skips when selected bit is one, no flags.
// - A taken skip adds a dummy cycle, two machine cycles total.
// - Set-byte writes all ones to memory, no flags.
// - Set-bit drives only the selected bit to one, no flags.
// - Nibble swap exchanges memory nibbles in place, no flags.

package rss_alu_pkg;

  localparam int unsigned DATA_W  = 8;
  localparam int unsigned OP_W    = 5;
  localparam logic [7:0]  ALL_ONES = 8'hff;
  localparam logic [7:0]  ACC_RST  = 8'h00;

  // Operation codes from the decoder
  typedef enum logic [4:0] {
    OP_NONE       = 5'h00,
    OP_RL_ACC     = 5'h01,
    OP_RCL_MEM    = 5'h02,
    OP_RCL_ACC    = 5'h03,
    OP_ROR_MEM    = 5'h04,
    OP_ROR_ACC    = 5'h05,
    OP_RCR_MEM    = 5'h06,
    OP_RCR_ACC    = 5'h07,
    OP_SBB_ACC    = 5'h08,
    OP_SBB_MEM    = 5'h09,
    OP_SUB_MEM    = 5'h0a,
    OP_SUB_IMM    = 5'h0b,
    OP_DSZ_MEM    = 5'h0c,
    OP_DSZ_ACC    = 5'h0d,
    OP_ISZ_MEM    = 5'h0e,
    OP_ISZ_ACC    = 5'h0f,
    OP_SKIP_BIT1  = 5'h10,
    OP_SET_BYTE   = 5'h11,
    OP_SET_BIT    = 5'h12,
    OP_SWAP_MEM   = 5'h13
  } op_t;

  // Sequencer states
  typedef enum logic [0:0] {
    ST_EXEC  = 1'b0,
    ST_DUMMY = 1'b1
  } seq_state_t;

endpackage : rss_alu_pkg

// >>> design/rss_sub_unit.sv
// Purpose: Eight-bit subtractor with borrow-in and status outputs
// Assumes: Carry input is the inverted borrow
// Notes:   Pure combinational, no state

`timescale 1ns/10ps

module rss_sub_unit (
  input  wire logic [7:0] minuend_i,
  input  wire logic [7:0] subtrahend_i,
  input  wire logic       carry_i,
  output logic      [7:0] diff_o,
  output logic            carry_o,
  output logic            half_o,
  output logic            ovf_o,
  output logic            zero_o
);

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // Add the complement; carry-out equals no borrow
  always_comb begin
    full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + {8'h00, carry_i};
    low_sum  = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]}
             + {4'h0, carry_i};
    diff_o   = full_sum[7:0];
    carry_o  = full_sum[8];
    half_o   = low_sum[4];
    // Sign error: operands differ in sign and result sign follows subtrahend
    ovf_o    = (minuend_i[7] ^ subtrahend_i[7])
             & (minuend_i[7] ^ full_sum[7]);
    zero_o   = (full_sum[7:0] == 8'h00);
  end

endmodule : rss_sub_unit

// >>> design/rss_alu.sv
// Purpose: Executes rotate, subtract, skip, set and swap operations
// Assumes: Memory byte and operands are valid in the cycle op_valid_i is high
// Notes:   Accumulator and flags live here; memory writes leave as strobes

`timescale 1ns/10ps

module rss_alu (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic       op_valid_i,
  input  wire logic [4:0] op_i,
  input  wire logic [7:0] mem_rd_i,
  input  wire logic [7:0] imm_i,
  input  wire logic [2:0] bit_sel_i,
  output logic            busy_o,
  output logic            mem_we_o,
  output logic      [7:0] mem_wd_o,
  output logic            skip_o,
  output logic            dummy_o,
  output logic      [7:0] acc_o,
  output logic            carry_flag_o,
  output logic            half_carry_flag_o,
  output logic            zero_flag_o,
  output logic            overflow_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    rss_alu_pkg::seq_state_t st;
    logic [7:0]              acc;
    logic                    cy;
    logic                    hc;
    logic                    zf;
    logic                    vf;
    logic                    we;
    logic [7:0]              wd;
    logic                    skip;
  } alu_state_t;

  alu_state_t cur_r;
  alu_state_t cur_nxt;

  rss_alu_pkg::op_t op;
  logic [7:0] sub_a;
  logic [7:0] sub_b;
  logic       sub_cin;
  logic [7:0] sub_d;
  logic       sub_c;
  logic       sub_h;
  logic       sub_v;
  logic       sub_z;
  logic [7:0] dec_v;
  logic [7:0] inc_v;
  logic [7:0] bit_mask;
  logic       accept;

  assign op     = rss_alu_pkg::op_t'(op_i);
  assign accept = op_valid_i && (cur_r.st == rss_alu_pkg::ST_EXEC);
  assign dec_v  = mem_rd_i - 8'h01;
  assign inc_v  = mem_rd_i + 8'h01;

  // One-hot mask of the selected bit
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      assign bit_mask[gi] = (bit_sel_i == 3'(gi));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Subtractor operand select

  always_comb begin
    sub_a   = cur_r.acc;
    sub_b   = mem_rd_i;
    sub_cin = 1'b1;
    unique case (op)
      rss_alu_pkg::OP_SBB_ACC,
      rss_alu_pkg::OP_SBB_MEM: sub_cin = cur_r.cy;
      rss_alu_pkg::OP_SUB_IMM: sub_b   = imm_i;
      default:                 sub_cin = 1'b1;
    endcase
  end

  rss_sub_unit u_sub (
    .minuend_i    (sub_a),
    .subtrahend_i (sub_b),
    .carry_i      (sub_cin),
    .diff_o       (sub_d),
    .carry_o      (sub_c),
    .half_o       (sub_h),
    .ovf_o        (sub_v),
    .zero_o       (sub_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Write strobe and skip are one-cycle pulses, cleared by default
  always_comb begin
    cur_nxt      = cur_r;
    cur_nxt.we   = 1'b0;
    cur_nxt.skip = 1'b0;
    cur_nxt.st   = rss_alu_pkg::ST_EXEC;
    if (accept) begin
      unique case (op)
        rss_alu_pkg::OP_RL_ACC:
          cur_nxt.acc = {mem_rd_i[6:0], mem_rd_i[7]};
        rss_alu_pkg::OP_RCL_MEM: begin
          cur_nxt.we = 1'b1;
          cur_nxt.wd = {mem_rd_i[6:0], cur_r.cy};
          cur_nxt.cy = mem_rd_i[7];
        end
        rss_alu_pkg::OP_RCL_ACC: begin
          cur_nxt.acc = {mem_rd_i[6:0], cur_r.cy};
          cur_nxt.cy  = mem_rd_i[7];
        end
        rss_alu_pkg::OP_ROR_MEM: begin
          cur_nxt.we = 1'b1;
          cur_nxt.wd = {mem_rd_i[0], mem_rd_i[7:1]};
        end
        rss_alu_pkg::OP_ROR_ACC:
          cur_nxt.acc = {mem_rd_i[0], mem_rd_i[7:1]};
        rss_alu_pkg::OP_RCR_MEM: begin
          cur_nxt.we = 1'b1;
          cur_nxt.wd = {cur_r.cy, mem_rd_i[7:1]};
          cur_nxt.cy = mem_rd_i[0];
        end
        rss_alu_pkg::OP_RCR_ACC: begin
          cur_nxt.acc = {cur_r.cy, mem_rd_i[7:1]};
          cur_nxt.cy  = mem_rd_i[0];
        end
        rss_alu_pkg::OP_SBB_ACC,
        rss_alu_pkg::OP_SUB_IMM,
        rss_alu_pkg::OP_SBB_MEM,
        rss_alu_pkg::OP_SUB_MEM: begin
          if (op == rss_alu_pkg::OP_SBB_ACC || op == rss_alu_pkg::OP_SUB_IMM)
            cur_nxt.acc = sub_d;
          else begin
            cur_nxt.we = 1'b1;
            cur_nxt.wd = sub_d;
          end
          cur_nxt.cy = sub_c;
          cur_nxt.hc = sub_h;
          cur_nxt.zf = sub_z;
          cur_nxt.vf = sub_v;
        end
        rss_alu_pkg::OP_DSZ_MEM: begin
          cur_nxt.we   = 1'b1;
          cur_nxt.wd   = dec_v;
          cur_nxt.skip = (dec_v == 8'h00);
        end
        rss_alu_pkg::OP_DSZ_ACC: begin
          cur_nxt.acc  = dec_v;
          cur_nxt.skip = (dec_v == 8'h00);
        end
        rss_alu_pkg::OP_ISZ_MEM: begin
          cur_nxt.we   = 1'b1;
          cur_nxt.wd   = inc_v;
          cur_nxt.skip = (inc_v == 8'h00);
        end
        rss_alu_pkg::OP_ISZ_ACC: begin
          cur_nxt.acc  = inc_v;
          cur_nxt.skip = (inc_v == 8'h00);
        end
        rss_alu_pkg::OP_SKIP_BIT1:
          cur_nxt.skip = |(mem_rd_i & bit_mask);
        rss_alu_pkg::OP_SET_BYTE: begin
          cur_nxt.we = 1'b1;
          cur_nxt.wd = rss_alu_pkg::ALL_ONES;
        end
        rss_alu_pkg::OP_SET_BIT: begin
          cur_nxt.we = 1'b1;
          cur_nxt.wd = mem_rd_i | bit_mask;
        end
        rss_alu_pkg::OP_SWAP_MEM: begin
          cur_nxt.we = 1'b1;
          cur_nxt.wd = {mem_rd_i[3:0], mem_rd_i[7:4]};
        end
        default: cur_nxt.we = 1'b0; // Unknown codes do nothing
      endcase
      // A taken skip holds the next cycle as a dummy
      if (cur_nxt.skip)
        cur_nxt.st = rss_alu_pkg::ST_DUMMY;
    end
  end

  // Single register bank for all state
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cur_r     <= '0;
      cur_r.acc <= rss_alu_pkg::ACC_RST;
    end else begin
      cur_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Busy decodes the state register so the decoder stalls in the dummy cycle
  assign busy_o            = (cur_r.st == rss_alu_pkg::ST_DUMMY);
  assign dummy_o           = (cur_r.st == rss_alu_pkg::ST_DUMMY);
  assign mem_we_o          = cur_r.we;
  assign mem_wd_o          = cur_r.wd;
  assign skip_o            = cur_r.skip;
  assign acc_o             = cur_r.acc;
  assign carry_flag_o      = cur_r.cy;
  assign half_carry_flag_o = cur_r.hc;
  assign zero_flag_o       = cur_r.zf;
  assign overflow_flag_o   = cur_r.vf;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_rotl_acc: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_RL_ACC |=> acc_o ==
      {$past(mem_rd_i[6:0]), $past(mem_rd_i[7])} && !mem_we_o
      && $stable(carry_flag_o))
    else $error("rotate left to acc wrong");

  a_rcl_mem: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_RCL_MEM |=> mem_we_o
      && mem_wd_o == {$past(mem_rd_i[6:0]), $past(carry_flag_o)}
      && carry_flag_o == $past(mem_rd_i[7]) && $stable(acc_o))
    else $error("rotate left through carry wrong");

  // Carry must come from the memory byte, not from the old accumulator
  a_rcl_acc: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_RCL_ACC |=> !mem_we_o
      && acc_o == {$past(mem_rd_i[6:0]), $past(carry_flag_o)}
      && carry_flag_o == $past(mem_rd_i[7]))
    else $error("rotate left through carry to acc wrong");

  a_rcr_acc: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_RCR_ACC |=> !mem_we_o
      && acc_o == {$past(carry_flag_o), $past(mem_rd_i[7:1])}
      && carry_flag_o == $past(mem_rd_i[0]))
    else $error("rotate right through carry to acc wrong");

  a_rcr_mem: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_RCR_MEM |=> mem_we_o
      && mem_wd_o == {$past(carry_flag_o), $past(mem_rd_i[7:1])}
      && carry_flag_o == $past(mem_rd_i[0]) && $stable(acc_o))
    else $error("rotate right through carry wrong");

  a_ror_mem: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_ROR_MEM |=> mem_we_o
      && mem_wd_o == {$past(mem_rd_i[0]), $past(mem_rd_i[7:1])}
      && $stable(carry_flag_o))
    else $error("rotate right memory wrong");

  a_ror_acc: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_ROR_ACC |=> !mem_we_o
      && acc_o == {$past(mem_rd_i[0]), $past(mem_rd_i[7:1])}
      && $stable(carry_flag_o))
    else $error("rotate right to acc wrong");

  a_sub_carry: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_SUB_MEM |=> mem_we_o
      && carry_flag_o == ($past(acc_o) >= $past(mem_rd_i))
      && mem_wd_o == 8'($past(acc_o) - $past(mem_rd_i)) && $stable(acc_o))
    else $error("subtract carry wrong");

  a_sbb_acc: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_SBB_ACC |=> acc_o ==
      8'($past(acc_o) - $past(mem_rd_i) - {7'h00, !$past(carry_flag_o)})
      && zero_flag_o == (acc_o == 8'h00))
    else $error("subtract with borrow wrong");

  // Immediate operand must replace the memory byte in the subtractor
  a_sub_imm: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_SUB_IMM |=> !mem_we_o
      && acc_o == 8'($past(acc_o) - $past(imm_i))
      && carry_flag_o == ($past(acc_o) >= $past(imm_i)))
    else $error("immediate subtract wrong");

  a_skip_dummy: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    skip_o |-> dummy_o ##1 !dummy_o)
    else $error("skip dummy cycle wrong");

  a_dsz_skip: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_DSZ_MEM |=>
      skip_o == ($past(mem_rd_i) == 8'h01) && mem_we_o)
    else $error("decrement skip wrong");

  a_isz_skip: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_ISZ_MEM |=> mem_we_o
      && skip_o == ($past(mem_rd_i) == 8'hff)
      && mem_wd_o == 8'($past(mem_rd_i) + 8'h01))
    else $error("increment skip wrong");

  a_bit_skip: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_SKIP_BIT1 |=>
      skip_o == $past(mem_rd_i[bit_sel_i]) && !mem_we_o)
    else $error("bit skip wrong");

  a_set_byte: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_SET_BYTE |=> mem_we_o
      && mem_wd_o == rss_alu_pkg::ALL_ONES && $stable(carry_flag_o))
    else $error("set byte wrong");

  a_single_cyc: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    accept && op == rss_alu_pkg::OP_SWAP_MEM |=> !busy_o && mem_we_o
      && mem_wd_o == {$past(mem_rd_i[3:0]), $past(mem_rd_i[7:4])})
    else $error("single cycle op wrong");

endmodule : rss_alu

// >>> testbench/rss_alu_bench.sv
// Purpose: Self-checking bench for the rotate/subtract/skip ALU
// Assumes: Inputs change at the falling edge, results land one edge later
// Notes:   Integer model runs beside the design and is compared per op

`timescale 1ns/10ps

module rotate_subtract_skip_alu_bench;

  logic       clk_i, nrst_i, op_valid_i;
  logic [4:0] op_i;
  logic [7:0] mem_rd_i, imm_i;
  logic [2:0] bit_sel_i;
  logic       busy_o, mem_we_o, skip_o, dummy_o;
  logic [7:0] mem_wd_o, acc_o;
  logic       carry_flag_o, half_carry_flag_o, zero_flag_o, overflow_flag_o;
  int         err_count, checked;
  logic [15:0] lfsr_r;
  // Model state, mirrors the accumulator and flags
  logic [7:0] m_acc;
  logic       m_c, m_h, m_z, m_v;

  rss_alu dut (.clk_i(clk_i), .nrst_i(nrst_i), .op_valid_i(op_valid_i),
    .op_i(op_i), .mem_rd_i(mem_rd_i), .imm_i(imm_i), .bit_sel_i(bit_sel_i),
    .busy_o(busy_o), .mem_we_o(mem_we_o), .mem_wd_o(mem_wd_o),
    .skip_o(skip_o), .dummy_o(dummy_o), .acc_o(acc_o),
    .carry_flag_o(carry_flag_o), .half_carry_flag_o(half_carry_flag_o),
    .zero_flag_o(zero_flag_o), .overflow_flag_o(overflow_flag_o));

  //////////////////////////////////////////////////////////////////////////
  // Clock, 50 ns period
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Pseudo-random source, fixed start so runs repeat
  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction : rnd

  task automatic chk_byte(input logic [7:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // Accumulator and all four flags against the model
  task automatic chk_state();
    chk_byte(acc_o, m_acc, "acc");
    chk_bit(carry_flag_o, m_c, "carry");
    chk_bit(half_carry_flag_o, m_h, "half carry");
    chk_bit(zero_flag_o, m_z, "zero");
    chk_bit(overflow_flag_o, m_v, "overflow");
  endtask : chk_state

  task automatic chk_idle();
    chk_bit(mem_we_o, 1'b0, "idle write");
    chk_bit(skip_o, 1'b0, "idle skip");
    chk_bit(busy_o, 1'b0, "idle busy");
    chk_state();
  endtask : chk_idle

  //////////////////////////////////////////////////////////////////////////
  // Asynchronous reset, also used in mid-run
  task automatic do_reset();
    nrst_i = 1'b0;
    op_valid_i = 1'b0;
    {m_acc, m_c, m_h, m_z, m_v} = {rss_alu_pkg::ACC_RST, 4'h0};
    repeat (3) @(negedge clk_i);
    chk_idle();
    nrst_i = 1'b1;
    @(negedge clk_i);
    chk_idle();
  endtask : do_reset

  // One operation: drive, predict, then compare at the next falling edge
  task automatic run_op(input logic v, input logic [4:0] op,
      input logic [7:0] m, input logic [7:0] x, input logic [2:0] b);
    logic [8:0] d;
    logic [4:0] hn;
    logic [7:0] s, wd;
    logic       we, sk, bo;
    op_valid_i = v;
    op_i = op;
    mem_rd_i = m;
    imm_i = x;
    bit_sel_i = b;
    {we, sk, wd, bo} = 11'h000;
    s = (op == rss_alu_pkg::OP_SUB_IMM) ? x : m;
    if (v) case (op)
      rss_alu_pkg::OP_RL_ACC:  m_acc = {m[6:0], m[7]};
      rss_alu_pkg::OP_RCL_MEM: begin
        {we, wd, m_c} = {1'b1, m[6:0], m_c, m[7]};
      end
      rss_alu_pkg::OP_RCL_ACC: {m_acc, m_c} = {m[6:0], m_c, m[7]};
      rss_alu_pkg::OP_ROR_MEM: {we, wd} = {1'b1, m[0], m[7:1]};
      rss_alu_pkg::OP_ROR_ACC: m_acc = {m[0], m[7:1]};
      rss_alu_pkg::OP_RCR_MEM: begin
        {we, wd, m_c} = {1'b1, m_c, m[7:1], m[0]};
      end
      rss_alu_pkg::OP_RCR_ACC: {m_acc, m_c} = {m_c, m[7:1], m[0]};
      rss_alu_pkg::OP_SBB_ACC, rss_alu_pkg::OP_SBB_MEM,
      rss_alu_pkg::OP_SUB_MEM, rss_alu_pkg::OP_SUB_IMM: begin
        bo = (op == rss_alu_pkg::OP_SBB_ACC || op == rss_alu_pkg::OP_SBB_MEM)
          ? ~m_c : 1'b0;
        d = {1'b0, m_acc} - {1'b0, s} - {8'h00, bo};
        hn = {1'b0, m_acc[3:0]} - {1'b0, s[3:0]} - {4'h0, bo};
        m_v = (m_acc[7] != s[7]) && (d[7] != m_acc[7]);
        {m_c, m_h, m_z} = {~d[8], ~hn[4], d[7:0] == 8'h00};
        if (op == rss_alu_pkg::OP_SBB_MEM || op == rss_alu_pkg::OP_SUB_MEM)
          {we, wd} = {1'b1, d[7:0]};
        else
          m_acc = d[7:0];
      end
      rss_alu_pkg::OP_DSZ_MEM: begin
        {we, wd} = {1'b1, m - 8'h01};
        sk = (wd == 8'h00);
      end
      rss_alu_pkg::OP_DSZ_ACC: begin
        m_acc = m - 8'h01;
        sk = (m_acc == 8'h00);
      end
      rss_alu_pkg::OP_ISZ_MEM: begin
        {we, wd} = {1'b1, m + 8'h01};
        sk = (wd == 8'h00);
      end
      rss_alu_pkg::OP_ISZ_ACC: begin
        m_acc = m + 8'h01;
        sk = (m_acc == 8'h00);
      end
      rss_alu_pkg::OP_SKIP_BIT1: sk = m[b];
      rss_alu_pkg::OP_SET_BYTE: {we, wd} = {1'b1, rss_alu_pkg::ALL_ONES};
      rss_alu_pkg::OP_SET_BIT: {we, wd} = {1'b1, m | (8'h01 << b)};
      rss_alu_pkg::OP_SWAP_MEM: {we, wd} = {1'b1, m[3:0], m[7:4]};
      default: ;
    endcase
    @(negedge clk_i);
    chk_bit(mem_we_o, we, "mem write");
    if (we) chk_byte(mem_wd_o, wd, "mem data");
    chk_bit(skip_o, sk, "skip");
    chk_bit(busy_o, sk, "busy");
    chk_bit(dummy_o, sk, "dummy");
    chk_state();
    if (sk) begin
      // Request during the dummy cycle must be ignored
      op_valid_i = 1'b1;
      op_i = rss_alu_pkg::OP_SET_BYTE;
      @(negedge clk_i);
      chk_idle();
    end
  endtask : run_op

  task automatic end_of_test();
    if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: every code twice, then random ops with edge-case bytes
  initial begin
    logic [15:0] r, q;
    logic [7:0]  mb;
    {nrst_i, op_valid_i, op_i, mem_rd_i, imm_i, bit_sel_i} = 26'h0;
    {err_count, checked} = {32'd0, 32'd0};
    lfsr_r = 16'h7e12;
    do_reset();
    for (int i = 0; i < 800; i++) begin
      if (i == 400) do_reset();
      r = rnd();
      q = rnd();
      case (q[2:0])
        3'h0: mb = 8'h01;
        3'h1: mb = 8'hff;
        3'h2: mb = 8'h00;
        3'h3: mb = m_acc;
        default: mb = r[7:0];
      endcase
      run_op(i < 64 || r[15:14] != 2'h0, (i < 64) ? i[4:0] : r[12:8], mb,
        q[15:8], q[5:3]);
    end
    end_of_test();
  end

  // Watchdog, well beyond the two cycles an op can take
  initial begin
    repeat (6000) @(posedge clk_i);
    err_count++;
    end_of_test();
  end

endmodule : rotate_subtract_skip_alu_bench
